// ===== rtl/pll_status_pkg.sv
// Register map, field layout and snapshot type of the PLL status bank
// Operation
// - Second channel status range is read only; writes leave it unchanged.
// - Writing 0x01 to update register refreshes copies from live status.
// - First channel status range is read only, same snapshot refresh.
// - Lock status bit 4 is one while analog oscillator calibration runs.
// - Lock status bit 3 shows analog loop lock, one meaning locked.
// - Lock status bit 2 shows digital loop frequency lock.
// - Lock status bit 1 shows digital loop phase lock.
// - Lock bit 0 is one only when system, analog, digital loops lock.
// - Loop state bits 4:3 encode selected reference, 00 A through 11 D.
// - Loop state bit 2 is set while switching references.
// - Loop state bit 1 is set while in holdover.
// - Loop state bit 0 is set while in free run.
// - Limit flags bit 2 is set while phase slew is limited.
// - Limit flags bit 1 is set while frequency is clamped.
// - Limit flags bit 0 is set once tuning word history is available.
// - 30-bit averaged tuning word in four bytes, little endian.
// - Minimum history timer makes history show the latest raw word.
// - Phase bucket level: low byte, then bits 11:8 in next low nibble.
// - Frequency bucket level: low byte, then bits 11:8 in next low nibble.
package pll_status_pkg;

  localparam int ADDR_W = 16;
  localparam int IDX_W  = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_UPDATE        = 12'h005;
  localparam logic [IDX_W-1:0] IDX_CH0_FIRST     = 12'hD20;
  localparam logic [IDX_W-1:0] IDX_CH0_TW_B0     = 12'hD23;
  localparam logic [IDX_W-1:0] IDX_CH0_TW_B1     = 12'hD24;
  localparam logic [IDX_W-1:0] IDX_CH0_TW_B2     = 12'hD25;
  localparam logic [IDX_W-1:0] IDX_CH0_TW_B3     = 12'hD26;
  localparam logic [IDX_W-1:0] IDX_CH0_PB_LOW    = 12'hD27;
  localparam logic [IDX_W-1:0] IDX_CH0_PB_HIGH   = 12'hD28;
  localparam logic [IDX_W-1:0] IDX_CH0_FB_LOW    = 12'hD29;
  localparam logic [IDX_W-1:0] IDX_CH0_FB_HIGH   = 12'hD2A;
  localparam logic [IDX_W-1:0] IDX_HIST_TIMER    = 12'hD30;
  localparam logic [IDX_W-1:0] IDX_CH1_LOCK      = 12'hD40;
  localparam logic [IDX_W-1:0] IDX_CH1_LOOP      = 12'hD41;
  localparam logic [IDX_W-1:0] IDX_CH1_LIMIT     = 12'hD42;
  localparam logic [IDX_W-1:0] IDX_CH1_LAST      = 12'hD4A;

  localparam logic [7:0] UPDATE_CMD       = 8'h01;
  localparam logic [7:0] HIST_TIMER_MIN   = 8'h00;
  localparam logic [7:0] HIST_TIMER_RESET = 8'h10;

  // Field positions
  localparam int LOCK_CAL_BIT    = 4;
  localparam int LOCK_ANALOG_BIT = 3;
  localparam int LOCK_FREQ_BIT   = 2;
  localparam int LOCK_PHASE_BIT  = 1;
  localparam int LOCK_ALL_BIT    = 0;
  localparam int LOOP_REF_LSB    = 3;
  localparam int LOOP_SWITCH_BIT = 2;
  localparam int LOOP_HOLD_BIT   = 1;
  localparam int LOOP_FREE_BIT   = 0;
  localparam int LIM_SLEW_BIT    = 2;
  localparam int LIM_CLAMP_BIT   = 1;
  localparam int LIM_HIST_BIT    = 0;

  localparam int TW_W     = 30;
  localparam int BUCKET_W = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REF_INPUT_A = 2'h0,
    REF_INPUT_B = 2'h1,
    REF_INPUT_C = 2'h2,
    REF_INPUT_D = 2'h3
  } ref_sel_t;

  typedef struct packed {
    logic                cal_busy;
    logic                analog_locked;
    logic                freq_locked;
    logic                phase_locked;
    logic                all_locked;
    ref_sel_t            active_ref;
    logic                switching;
    logic                holdover;
    logic                free_run;
    logic                slew_limited;
    logic                freq_clamped;
    logic                history_avail;
    logic [TW_W-1:0]     tuning_word;
    logic [BUCKET_W-1:0] phase_bucket;
    logic [BUCKET_W-1:0] freq_bucket;
  } status_t;

endpackage

// ===== rtl/pll_status_snapshot.sv
// Snapshot store that freezes live status on an update strobe
`timescale 1ns/10ps
`default_nettype none
module pll_status_snapshot
  import pll_status_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         capture,
  input  wire logic [W-1:0] live,
  output var  logic [W-1:0] held
);

  typedef struct packed {
    logic [W-1:0] held;
  } snap_state_t;

  snap_state_t s;
  snap_state_t next_s;

  // Whole vector loads at once so multi-byte fields stay coherent
  always_comb begin
    next_s = s;
    if (capture) begin
      next_s.held = live;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign held = s.held;

  chk_held_stable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !capture |=> $stable(held))
    else $error("status copy changed without update");

endmodule
`default_nettype wire

// ===== rtl/pll_status_regs.sv
// AXI4-Lite read-only status bank for two clock-synthesis channels
`timescale 1ns/10ps
`default_nettype none
module pll_status_regs
  import pll_status_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [TW_W-1:0]     digital_loop_a_tw_avg,
  input  wire logic [TW_W-1:0]     digital_loop_a_tw_recent,
  input  wire logic [BUCKET_W-1:0] digital_loop_a_phase_bucket,
  input  wire logic [BUCKET_W-1:0] digital_loop_a_freq_bucket,
  input  wire logic                sysclk_pll_locked,
  input  wire logic                analog_loop_b_cal_busy,
  input  wire logic                analog_loop_b_locked,
  input  wire logic                digital_loop_b_freq_locked,
  input  wire logic                digital_loop_b_phase_locked,
  input  wire logic [1:0]          digital_loop_b_active_ref,
  input  wire logic                digital_loop_b_switching,
  input  wire logic                digital_loop_b_holdover,
  input  wire logic                digital_loop_b_free_run,
  input  wire logic                digital_loop_b_slew_limited,
  input  wire logic                digital_loop_b_freq_clamped,
  input  wire logic                digital_loop_b_history_avail
);

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  typedef struct packed {
    wr_state_t        wr;
    rd_state_t        rd;
    logic             awready;
    logic             wready;
    logic             aw_got;
    logic             w_got;
    logic [IDX_W-1:0] waddr;
    logic [7:0]       wbyte;
    logic             wlane;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             upd;
    logic [7:0]       hist_timer;
  } state_t;

  state_t  s;
  state_t  next_s;
  status_t live;
  status_t snap;

  function automatic logic [IDX_W-1:0] to_index(
    input logic [ADDR_W-1:0] addr
  );
    to_index = addr[IDX_W+1:2];
  endfunction

  function automatic logic in_status(input logic [IDX_W-1:0] idx);
    in_status = (idx >= IDX_CH0_FIRST && idx <= IDX_CH0_FB_HIGH) ||
                (idx >= IDX_CH1_LOCK && idx <= IDX_CH1_LAST);
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = in_status(idx) || idx == IDX_UPDATE ||
                idx == IDX_HIST_TIMER;
  endfunction

  // Status bytes; unlisted indices inside the ranges read zero
  function automatic logic [7:0] read_byte(
    input logic [IDX_W-1:0] idx,
    input status_t          st,
    input logic [7:0]       hist
  );
    logic [7:0] b;
    b = 8'h00;
    if (idx == IDX_CH0_TW_B0) begin
      b = st.tuning_word[7:0];
    end else if (idx == IDX_CH0_TW_B1) begin
      b = st.tuning_word[15:8];
    end else if (idx == IDX_CH0_TW_B2) begin
      b = st.tuning_word[23:16];
    end else if (idx == IDX_CH0_TW_B3) begin
      b = {2'h0, st.tuning_word[29:24]};
    end else if (idx == IDX_CH0_PB_LOW) begin
      b = st.phase_bucket[7:0];
    end else if (idx == IDX_CH0_PB_HIGH) begin
      b = {4'h0, st.phase_bucket[11:8]};
    end else if (idx == IDX_CH0_FB_LOW) begin
      b = st.freq_bucket[7:0];
    end else if (idx == IDX_CH0_FB_HIGH) begin
      b = {4'h0, st.freq_bucket[11:8]};
    end else if (idx == IDX_CH1_LOCK) begin
      b[LOCK_CAL_BIT]    = st.cal_busy;
      b[LOCK_ANALOG_BIT] = st.analog_locked;
      b[LOCK_FREQ_BIT]   = st.freq_locked;
      b[LOCK_PHASE_BIT]  = st.phase_locked;
      b[LOCK_ALL_BIT]    = st.all_locked;
    end else if (idx == IDX_CH1_LOOP) begin
      b[LOOP_REF_LSB+:2]  = st.active_ref;
      b[LOOP_SWITCH_BIT]  = st.switching;
      b[LOOP_HOLD_BIT]    = st.holdover;
      b[LOOP_FREE_BIT]    = st.free_run;
    end else if (idx == IDX_CH1_LIMIT) begin
      b[LIM_SLEW_BIT]  = st.slew_limited;
      b[LIM_CLAMP_BIT] = st.freq_clamped;
      b[LIM_HIST_BIT]  = st.history_avail;
    end else if (idx == IDX_HIST_TIMER) begin
      b = hist;
    end
    read_byte = b;
  endfunction

  // Live view assembled ahead of the snapshot store
  always_comb begin
    live.cal_busy      = analog_loop_b_cal_busy;
    live.analog_locked = analog_loop_b_locked;
    live.freq_locked   = digital_loop_b_freq_locked;
    live.phase_locked  = digital_loop_b_phase_locked;
    live.all_locked    = sysclk_pll_locked && analog_loop_b_locked &&
                         digital_loop_b_freq_locked &&
                         digital_loop_b_phase_locked;
    live.active_ref    = ref_sel_t'(digital_loop_b_active_ref);
    live.switching     = digital_loop_b_switching;
    live.holdover      = digital_loop_b_holdover;
    live.free_run      = digital_loop_b_free_run;
    live.slew_limited  = digital_loop_b_slew_limited;
    live.freq_clamped  = digital_loop_b_freq_clamped;
    live.history_avail = digital_loop_b_history_avail;
    // Minimum accumulation time bypasses the averager
    live.tuning_word   = (s.hist_timer == HIST_TIMER_MIN) ?
                         digital_loop_a_tw_recent :
                         digital_loop_a_tw_avg;
    live.phase_bucket  = digital_loop_a_phase_bucket;
    live.freq_bucket   = digital_loop_a_freq_bucket;
  end

  pll_status_snapshot #(
    .W ($bits(status_t))
  ) u_snapshot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .capture (s.upd),
    .live    (live),
    .held    (snap)
  );

  always_comb begin
    next_s     = s;
    next_s.upd = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr  = to_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wbyte = s_axi_wdata[7:0];
      next_s.wlane = s_axi_wstrb[0];
    end
    case (s.wr)
      WR_IDLE: begin
        if (next_s.aw_got && next_s.w_got) begin
          next_s.bresp = RESP_OKAY;
          if (next_s.waddr == IDX_UPDATE) begin
            next_s.upd = next_s.wlane &&
                         next_s.wbyte == UPDATE_CMD;
          end else if (next_s.waddr == IDX_HIST_TIMER) begin
            if (next_s.wlane) begin
              next_s.hist_timer = next_s.wbyte;
            end
          end else if (!in_status(next_s.waddr)) begin
            next_s.bresp = RESP_SLVERR;
          end
          // Status range: accepted with OKAY, contents untouched
          next_s.aw_got = 1'b0;
          next_s.w_got  = 1'b0;
          next_s.bvalid = 1'b1;
          next_s.wr     = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_s.bvalid = 1'b0;
          next_s.wr     = WR_IDLE;
        end
      end
      default: begin
        next_s.wr = WR_IDLE;
      end
    endcase
    next_s.awready = !next_s.aw_got && next_s.wr == WR_IDLE;
    next_s.wready  = !next_s.w_got && next_s.wr == WR_IDLE;
    case (s.rd)
      RD_IDLE: begin
        if (s_axi_arvalid && s.arready) begin
          next_s.rdata  = {24'h000000,
                           read_byte(to_index(s_axi_araddr), snap,
                                     s.hist_timer)};
          next_s.rresp  = is_mapped(to_index(s_axi_araddr)) ?
                          RESP_OKAY : RESP_SLVERR;
          next_s.rvalid = 1'b1;
          next_s.rd     = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          next_s.rvalid = 1'b0;
          next_s.rd     = RD_IDLE;
        end
      end
      default: begin
        next_s.rd = RD_IDLE;
      end
    endcase
    next_s.arready = next_s.rd == RD_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s            <= '0;
      s.wr         <= WR_IDLE;
      s.rd         <= RD_IDLE;
      s.hist_timer <= HIST_TIMER_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;

  chk_update_strobe: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.wr == WR_IDLE && s_axi_awvalid && s.awready && s_axi_wvalid &&
    s.wready && to_index(s_axi_awaddr) == IDX_UPDATE &&
    s_axi_wstrb[0] && s_axi_wdata[7:0] == UPDATE_CMD
    |=> s.upd ##1 snap == $past(live))
    else $error("update write did not refresh status copy");

  chk_all_locked: assert property (
    @(posedge aclk) disable iff (!aresetn)
    snap.all_locked |-> snap.analog_locked && snap.freq_locked &&
    snap.phase_locked)
    else $error("all-locked set while a loop is unlocked");

  chk_hist_bypass: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.hist_timer == HIST_TIMER_MIN |->
    live.tuning_word == digital_loop_a_tw_recent)
    else $error("minimum timer did not select raw tuning word");

  chk_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  chk_loop_ref: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    to_index(s_axi_araddr) == IDX_CH1_LOOP
    |=> s_axi_rvalid && s_axi_rdata[4:3] == $past(snap.active_ref) &&
    s_axi_rdata[7:5] == 3'h0)
    else $error("loop state reference field wrong");

  chk_lock_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    to_index(s_axi_araddr) == IDX_CH1_LOCK
    |=> s_axi_rdata[7:1] == {3'h0, $past(snap.cal_busy),
    $past(snap.analog_locked), $past(snap.freq_locked),
    $past(snap.phase_locked)})
    else $error("lock status fields wrong");

  chk_limit_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    to_index(s_axi_araddr) == IDX_CH1_LIMIT
    |=> s_axi_rdata[7:0] == {5'h00, $past(snap.slew_limited),
    $past(snap.freq_clamped), $past(snap.history_avail)})
    else $error("limit flag fields wrong");

  chk_tw_top: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    to_index(s_axi_araddr) == IDX_CH0_TW_B3
    |=> s_axi_rdata[7:0] == {2'h0, $past(snap.tuning_word[29:24])})
    else $error("tuning word top byte wrong");

  chk_bucket_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    to_index(s_axi_araddr) == IDX_CH0_PB_HIGH
    |=> s_axi_rdata[7:0] == {4'h0, $past(snap.phase_bucket[11:8])})
    else $error("phase bucket high byte wrong");

  chk_ro_no_strobe: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.wr == WR_IDLE && s_axi_awvalid && s.awready &&
    in_status(to_index(s_axi_awaddr)) |=> !s.upd)
    else $error("status range write caused update");

  chk_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");

  chk_write_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write answer not one cycle after address and data");

  chk_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");

  chk_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the PLL status register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pll_status_pkg::*;
;
  logic                aclk;
  logic                aresetn;
  logic [ADDR_W-1:0]   awaddr;
  logic                awvalid;
  logic                awready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [ADDR_W-1:0]   araddr;
  logic                arvalid;
  logic                arready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  logic [TW_W-1:0]     tw_avg;
  logic [TW_W-1:0]     tw_recent;
  logic [BUCKET_W-1:0] pbkt;
  logic [BUCKET_W-1:0] fbkt;
  // Live flags: 12 sys, 11 cal, 10 analog, 9 freq, 8 phase, 7:6 ref,
  // 5 switch, 4 hold, 3 free, 2 slew, 1 clamp, 0 history
  logic [12:0]         lv;
  logic [12:0]         s_lv;
  logic [TW_W-1:0]     s_tw;
  logic [BUCKET_W-1:0] s_pb;
  logic [BUCKET_W-1:0] s_fb;
  logic [7:0]          timer;
  logic [31:0]         seed;
  logic [1:0]          resp;
  logic [31:0]         data;
  int                  errors;
  int                  n_tests;
  logic [IDX_W-1:0]    regs [13];

  pll_status_regs i_dut (
    .aclk                         (aclk),
    .aresetn                      (aresetn),
    .s_axi_awaddr                 (awaddr),
    .s_axi_awvalid                (awvalid),
    .s_axi_awready                (awready),
    .s_axi_wdata                  (wdata),
    .s_axi_wstrb                  (wstrb),
    .s_axi_wvalid                 (wvalid),
    .s_axi_wready                 (wready),
    .s_axi_bresp                  (bresp),
    .s_axi_bvalid                 (bvalid),
    .s_axi_bready                 (bready),
    .s_axi_araddr                 (araddr),
    .s_axi_arvalid                (arvalid),
    .s_axi_arready                (arready),
    .s_axi_rdata                  (rdata),
    .s_axi_rresp                  (rresp),
    .s_axi_rvalid                 (rvalid),
    .s_axi_rready                 (rready),
    .digital_loop_a_tw_avg        (tw_avg),
    .digital_loop_a_tw_recent     (tw_recent),
    .digital_loop_a_phase_bucket  (pbkt),
    .digital_loop_a_freq_bucket   (fbkt),
    .sysclk_pll_locked            (lv[12]),
    .analog_loop_b_cal_busy       (lv[11]),
    .analog_loop_b_locked         (lv[10]),
    .digital_loop_b_freq_locked   (lv[9]),
    .digital_loop_b_phase_locked  (lv[8]),
    .digital_loop_b_active_ref    (lv[7:6]),
    .digital_loop_b_switching     (lv[5]),
    .digital_loop_b_holdover      (lv[4]),
    .digital_loop_b_free_run      (lv[3]),
    .digital_loop_b_slew_limited  (lv[2]),
    .digital_loop_b_freq_clamped  (lv[1]),
    .digital_loop_b_history_avail (lv[0])
  );

  always #10 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_byte(input logic [IDX_W-1:0] idx);
    logic all;
    all = s_lv[12] & s_lv[10] & s_lv[9] & s_lv[8];
    case (idx)
      IDX_CH0_TW_B0:   exp_byte = {24'h0, s_tw[7:0]};
      IDX_CH0_TW_B1:   exp_byte = {24'h0, s_tw[15:8]};
      IDX_CH0_TW_B2:   exp_byte = {24'h0, s_tw[23:16]};
      IDX_CH0_TW_B3:   exp_byte = {26'h0, s_tw[29:24]};
      IDX_CH0_PB_LOW:  exp_byte = {24'h0, s_pb[7:0]};
      IDX_CH0_PB_HIGH: exp_byte = {28'h0, s_pb[11:8]};
      IDX_CH0_FB_LOW:  exp_byte = {24'h0, s_fb[7:0]};
      IDX_CH0_FB_HIGH: exp_byte = {28'h0, s_fb[11:8]};
      IDX_CH1_LOCK:    exp_byte = {27'h0, s_lv[11:8], all};
      IDX_CH1_LOOP:    exp_byte = {27'h0, s_lv[7:3]};
      IDX_CH1_LIMIT:   exp_byte = {29'h0, s_lv[2:0]};
      default:         exp_byte = 32'h0;
    endcase
  endfunction

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready sometimes held back two cycles so the slave must keep its answer
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d);
    int n;
    int lag;
    bit ok;
    n = 0;
    ok = 1'b0;
    seed = lfsr(seed);
    lag = seed[0] ? 2 : 0;
    resp = 2'h3;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    while (!ok && n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end else if (n == lag) begin
        bready <= 1'b1;
      end
    end
    // Idle edge so the next call never re-drives ready in this time step
    @(posedge aclk);
    if (!ok) begin
      check("write timeout", 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  task automatic axi_read(input logic [15:0] a);
    int n;
    int lag;
    bit ok;
    n = 0;
    ok = 1'b0;
    seed = lfsr(seed);
    lag = seed[0] ? 2 : 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    while (!ok && n < 50) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) begin
        resp = rresp;
        data = rdata;
        rready <= 1'b0;
        ok = 1'b1;
      end else if (n == lag) begin
        rready <= 1'b1;
      end
    end
    @(posedge aclk);
    if (!ok) begin
      check("read timeout", 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  // Reserved slots 0xD20 and 0xD43 must read zero alongside mapped ones
  task automatic read_all();
    foreach (regs[i]) begin
      axi_read({2'b00, regs[i], 2'b00});
      check("status byte", exp_byte(regs[i]), data);
      check("status resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
  endtask

  task automatic set_live(input int k);
    logic [12:0] v;
    seed = lfsr(seed);
    tw_avg <= seed[29:0];
    seed = lfsr(seed);
    tw_recent <= seed[29:0];
    seed = lfsr(seed);
    pbkt <= seed[11:0];
    fbkt <= seed[23:12];
    seed = lfsr(seed);
    v = (k == 0) ? 13'h1FFF : (k == 1) ? 13'h0FFF : seed[12:0];
    if (k > 1)
      v[7:6] = k[1:0];
    lv <= v;
  endtask

  task automatic update(input logic [31:0] v);
    axi_write({2'b00, IDX_UPDATE, 2'b00}, v);
    check("update resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    if (v == {24'h0, UPDATE_CMD}) begin
      s_lv = lv;
      s_tw = (timer == HIST_TIMER_MIN) ? tw_recent : tw_avg;
      s_pb = pbkt;
      s_fb = fbkt;
    end
  endtask

  initial begin
    regs = '{IDX_CH0_FIRST, IDX_CH0_TW_B0, IDX_CH0_TW_B1, IDX_CH0_TW_B2,
             IDX_CH0_TW_B3, IDX_CH0_PB_LOW, IDX_CH0_PB_HIGH, IDX_CH0_FB_LOW,
             IDX_CH0_FB_HIGH, IDX_CH1_LOCK, IDX_CH1_LOOP, IDX_CH1_LIMIT,
             12'hD43};
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, tw_avg, tw_recent, pbkt, fbkt, lv} = '0;
    {s_lv, s_tw, s_pb, s_fb} = '0;
    timer = HIST_TIMER_RESET;
    seed = 32'hAF25DF44;
    errors = 0;
    n_tests = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    read_all();
    axi_read({2'b00, IDX_HIST_TIMER, 2'b00});
    check("timer reset", {24'h0, HIST_TIMER_RESET}, data);
    $display("Test reset values done");
    // Corner cases first: all locked, then all but the system clock
    for (int k = 0; k < 12; k++) begin
      timer = (k % 3 == 2) ? HIST_TIMER_MIN : HIST_TIMER_RESET;
      axi_write({2'b00, IDX_HIST_TIMER, 2'b00}, {24'h0, timer});
      set_live(k);
      @(posedge aclk);
      update({24'h0, UPDATE_CMD});
      set_live(-1);
      read_all();
      update(32'h2);
      read_all();
    end
    $display("Test snapshot contents done");
    foreach (regs[i]) begin
      axi_write({2'b00, regs[i], 2'b00}, 32'hFFFF_FFFF);
      check("ro write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    read_all();
    $display("Test read-only ranges done");
    axi_read(16'h0100);
    check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    check("unmapped rdata", 32'h0, data);
    axi_write(16'h0100, 32'h0000_00A5);
    check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    $display("Test unmapped access done");
    give_verdict();
  end
endmodule
`default_nettype wire
